// ---- design/fault_alert_dev.sv ----
// fault alert device end: serial frames, check byte, watchdog and fault pin
//
// Summary of operation
// - every fault drives pin and fault bit
// - lost link forces loop to alarm
// - host reads fault register on pin high
// - watchdog frozen while alarm active
// - timed-out watchdog waits for fault read
// - no valid access in timeout raises fault
// - watchdog timeout sets serial fault bit
// - direction strap picks upscale or downscale
// - 32-bit frame carries check byte last
// - host builds check byte with CRC-8
// - host shifts all 24 or 32 bits before sync
// - bad check byte: pin and error bit
// - fault read clears error bit and pin
// - readback of 32-bit frame appends check
// - loop below target sets low flag
// - loop above target sets high flag, pin
// - high temperature bit drives pin
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
module fault_alert_dev
  import fault_alert_pkg::*;
#(
  parameter int WDT_UNIT = WDT_UNIT_CYC // cycles per watchdog step
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  fault_link_if.dev lnk, // serial link
  input wire logic alarm_up, // strap: high upscale alarm
  input wire logic loop_under, // monitor: loop below target
  input wire logic loop_over, // monitor: loop above target
  input wire logic temp_hi, // monitor: die too hot
  output logic [15:0] loop_code, // code driving the loop
  output logic alarm_on // loop forced to alarm
);
  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] sclk_s, sync_s, din_s, up_s, und_s, ovr_s, tmp_s; // two-stage syncs
  logic sclk_d, sync_d; // third stage for edges

  // every outside level passes two flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_s <= 2'h0;
      sync_s <= 2'h3;
      din_s <= 2'h0;
      up_s <= 2'h0;
      und_s <= 2'h0;
      ovr_s <= 2'h0;
      tmp_s <= 2'h0;
      sclk_d <= 1'b0;
      sync_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], lnk.sclk};
      sync_s <= {sync_s[0], lnk.sync_n};
      din_s <= {din_s[0], lnk.sdin};
      up_s <= {up_s[0], alarm_up};
      und_s <= {und_s[0], loop_under};
      ovr_s <= {ovr_s[0], loop_over};
      tmp_s <= {tmp_s[0], temp_hi};
      sclk_d <= sclk_s[1];
      sync_d <= sync_s[1];
    end
  end

  logic sclk_rise, sclk_fall, f_start, f_end; // edge events
  assign sclk_rise = sclk_s[1] & ~sclk_d & ~sync_s[1];
  assign sclk_fall = ~sclk_s[1] & sclk_d & ~sync_s[1];
  assign f_start = ~sync_s[1] & sync_d;
  assign f_end = sync_s[1] & ~sync_d;

  ////////////////////////////////////////////////////////////////
  // receive shifter
  logic [31:0] rx_r; // incoming bits, last in lsb
  logic [5:0] nbit_r; // bits received this frame

  // shift on each serial rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_r <= 32'h0;
      nbit_r <= 6'h0;
    end else if (f_start) begin
      nbit_r <= 6'h0;
    end else if (sclk_rise) begin
      rx_r <= {rx_r[30:0], din_s[1]};
      if (nbit_r != 6'h3f) begin
        nbit_r <= nbit_r + 6'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // frame decode
  logic chk_frame, plain_frame, crc_ok; // frame kinds
  logic [23:0] word; // command and data part
  logic [6:0] adr; // addressed register
  logic adr_ok, good, bad; // frame verdicts
  assign chk_frame = f_end && nbit_r == 6'(CHK_BITS);
  assign plain_frame = f_end && nbit_r == 6'(FRAME_BITS);
  assign word = chk_frame ? rx_r[31:8] : rx_r[23:0]; // check byte is the low byte
  assign crc_ok = crc8_24(rx_r[31:8]) == rx_r[7:0];
  assign adr = word[ADR_HI:ADR_LO];
  assign adr_ok = adr == ADR_NOP || adr == ADR_DAC || adr == ADR_CTRL || adr == ADR_FAULT;
  assign good = (plain_frame || (chk_frame && crc_ok)) && adr_ok;
  assign bad = chk_frame && !crc_ok;

  ////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] dac_r, ctrl_r; // loop code and control
  logic [15:0] fault_w; // live fault register view
  logic pkt_err_r, spi_r; // sticky fault bits
  logic flt_read; // fault register loaded for readback

  // writes only from frames that pass every check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_r <= DAC_RST;
      ctrl_r <= CTRL_RST;
    end else if (good && !word[RD_BIT]) begin
      if (adr == ADR_DAC) begin
        dac_r <= word[15:0];
      end else if (adr == ADR_CTRL) begin
        ctrl_r <= word[15:0];
      end
    end
  end

  // check error flag, set beats the clear of a fault read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt_err_r <= 1'b0;
    end else if (bad) begin
      pkt_err_r <= 1'b1;
    end else if (flt_read) begin
      pkt_err_r <= 1'b0;
    end
  end

  always_comb begin
    fault_w = 16'h0;
    fault_w[FLT_SPI] = spi_r;
    fault_w[FLT_PKT_ERR] = pkt_err_r;
    fault_w[FLT_UNDER] = und_s[1];
    fault_w[FLT_OVER] = ovr_s[1];
    fault_w[FLT_TEMP] = tmp_s[1];
  end

  ////////////////////////////////////////////////////////////////
  // watchdog
  logic [31:0] wdt_r; // cycles since last valid access
  logic [31:0] wdt_lim; // selected timeout
  assign wdt_lim = 32'(WDT_UNIT) << ctrl_r[CTL_TSEL_LO +: 3];

  // count idle time, freeze on alarm until fault read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_r <= 32'h0;
      spi_r <= 1'b0;
    end else if (!ctrl_r[CTL_WDT_EN]) begin
      wdt_r <= 32'h0;
      spi_r <= 1'b0;
    end else if (spi_r) begin
      if (flt_read) begin // resumes only after fault read
        spi_r <= 1'b0;
        wdt_r <= 32'h0;
      end // no restart while alarm active
    end else if (good) begin
      wdt_r <= 32'h0;
    end else if (wdt_r >= wdt_lim - 32'h1) begin
      spi_r <= 1'b1;
    end else begin
      wdt_r <= wdt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // readback and transmit
  logic [23:0] resp_r; // word for next frame
  logic resp_chk_r, resp_flt_r; // append check, holds fault reg
  logic [31:0] tx_r; // outgoing bits, msb out
  logic [15:0] rd_val; // value of addressed register

  always_comb begin
    case (adr)
      ADR_DAC: rd_val = dac_r;
      ADR_CTRL: rd_val = ctrl_r;
      ADR_FAULT: rd_val = fault_w;
      default: rd_val = 16'h0;
    endcase
  end

  // choose reply: requested register, or fault register on auto readback
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_r <= 24'h0;
      resp_chk_r <= 1'b0;
      resp_flt_r <= 1'b0;
    end else if (good && (word[RD_BIT] || !ctrl_r[CTL_ARB_DIS])) begin
      resp_chk_r <= chk_frame;
      if (word[RD_BIT]) begin
        resp_r <= {1'b0, adr, rd_val};
        resp_flt_r <= adr == ADR_FAULT;
      end else begin
        resp_r <= {1'b0, ADR_FAULT, fault_w};
        resp_flt_r <= 1'b1;
      end
    end else if (f_start) begin
      resp_flt_r <= 1'b0;
    end
  end

  // fault register counts as read when its reply starts out
  assign flt_read = f_start && resp_flt_r;

  // shift reply out on falling edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_r <= 32'h0;
    end else if (f_start) begin
      tx_r <= {resp_r, resp_chk_r ? crc8_24(resp_r) : 8'h00};
    end else if (sclk_fall) begin
      tx_r <= {tx_r[30:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  logic sdo_r, fault_r; // pin flops

  // pin and loop drive from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sdo_r <= 1'b0;
      fault_r <= 1'b0;
      loop_code <= DAC_RST;
      alarm_on <= 1'b0;
    end else begin
      sdo_r <= tx_r[31];
      fault_r <= |fault_w;
      alarm_on <= spi_r;
      if (spi_r) begin
        loop_code <= up_s[1] ? ALARM_UP_CODE : ALARM_DN_CODE;
      end else begin
        loop_code <= dac_r;
      end
    end
  end

  assign lnk.sdo = sdo_r;
  assign lnk.fault = fault_r;
endmodule // fault_alert_dev

// ---- design/fault_alert_host.sv ----
// host end: ahb-lite registers, serial frame master, check byte generator
module fault_alert_host
  import fault_alert_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write flag
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  output logic irq, // level interrupt
  fault_link_if.host lnk // serial link
);
  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] sdo_s, flt_s; // two-stage syncs
  logic flt_d; // for fault rise

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sdo_s <= 2'h0;
      flt_s <= 2'h0;
      flt_d <= 1'b0;
    end else begin
      sdo_s <= {sdo_s[0], lnk.sdo};
      flt_s <= {flt_s[0], lnk.fault};
      flt_d <= flt_s[1];
    end
  end

  ////////////////////////////////////////////////////////////////
  // ahb slave
  logic wr_ph_r; // write data phase pending
  logic [7:0] wadr_r; // write address
  logic go; // address phase taken
  logic [1:0] irq_st_r, irq_msk_r; // sticky events and mask
  logic [31:0] rxd_r; // received bits
  logic busy_r; // frame in progress
  logic cmd_wr, st_rd; // command write, status read
  logic done_ev; // frame finished

  assign go = hsel && htrans[1] && hready;
  assign cmd_wr = wr_ph_r && wadr_r == A_CMD && !busy_r; // ignored while busy
  assign st_rd = go && !hwrite && haddr == A_IRQ_ST;

  // capture address phase, read data from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r <= 1'b0;
      wadr_r <= 8'h0;
      hrdata <= 32'h0;
      irq_msk_r <= 2'h0;
    end else begin
      wr_ph_r <= go && hwrite;
      if (go) begin
        wadr_r <= haddr;
      end
      if (wr_ph_r && wadr_r == A_IRQ_MSK) begin
        irq_msk_r <= hwdata[1:0];
      end
      if (go && !hwrite) begin
        case (haddr)
          A_STAT: hrdata <= {30'h0, flt_s[1], busy_r};
          A_RXD: hrdata <= rxd_r;
          A_IRQ_ST: hrdata <= {30'h0, irq_st_r};
          A_IRQ_MSK: hrdata <= {30'h0, irq_msk_r};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // sticky events, set beats read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_st_r[IRQ_DONE] <= done_ev | (irq_st_r[IRQ_DONE] & ~st_rd);
      irq_st_r[IRQ_FAULT] <= (flt_s[1] & ~flt_d) | (irq_st_r[IRQ_FAULT] & ~st_rd);
      irq <= |(irq_st_r & irq_msk_r);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////
  // serial frame master
  host_st_t st_r; // frame state
  logic [4:0] div_r; // half period divider
  logic tick; // half period elapsed
  logic [31:0] tx_r; // outgoing bits
  logic [5:0] n_r, len_r; // bits sent, frame length
  logic sclk_r, sync_r; // pin flops

  assign tick = div_r == 5'(SCLK_HALF_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= H_IDLE;
      div_r <= 5'h0;
      tx_r <= 32'h0;
      n_r <= 6'h0;
      len_r <= 6'h0;
      sclk_r <= 1'b0;
      sync_r <= 1'b1;
      busy_r <= 1'b0;
      rxd_r <= 32'h0;
      done_ev <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      div_r <= (st_r == H_IDLE || tick) ? 5'h0 : div_r + 5'h1;
      case (st_r)
        H_IDLE: begin
          if (cmd_wr) begin
            busy_r <= 1'b1;
            sync_r <= 1'b0;
            n_r <= 6'h0;
            if (hwdata[CMD_CRC_BIT]) begin
              tx_r <= {hwdata[23:0], crc8_24(hwdata[23:0])};
              len_r <= 6'(CHK_BITS);
            end else begin
              tx_r <= {hwdata[23:0], 8'h00};
              len_r <= 6'(FRAME_BITS);
            end
            st_r <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick && !sclk_r) begin
            sclk_r <= 1'b1;
            rxd_r <= {rxd_r[30:0], sdo_s[1]};
          end else if (tick) begin
            sclk_r <= 1'b0;
            tx_r <= {tx_r[30:0], 1'b0};
            n_r <= n_r + 6'h1;
            if (n_r == len_r - 6'h1) begin
              st_r <= H_END; // all bits out before sync rises
            end
          end
        end
        H_END: begin
          if (tick) begin
            sync_r <= 1'b1;
            busy_r <= 1'b0;
            done_ev <= 1'b1;
            st_r <= H_IDLE;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign lnk.sclk = sclk_r;
  assign lnk.sync_n = sync_r;
  assign lnk.sdin = tx_r[31];
endmodule // fault_alert_host

// ---- include/fault_alert_pkg.sv ----
// shared constants, frame layout and check-byte function for the fault alert link
package fault_alert_pkg;
  // frame layout
  localparam int FRAME_BITS = 24; // plain frame length
  localparam int CHK_BITS = 32; // frame length with check byte
  localparam int RD_BIT = 23; // read request flag
  localparam int ADR_HI = 22; // address field top
  localparam int ADR_LO = 16; // address field bottom
  localparam logic [7:0] CRC_POLY = 8'h07; // x^8 + x^2 + x + 1
  localparam logic [7:0] CRC_INIT = 8'h00; // zero initial remainder
  // device register addresses
  localparam logic [6:0] ADR_NOP = 7'h00; // no operation
  localparam logic [6:0] ADR_DAC = 7'h01; // loop current code
  localparam logic [6:0] ADR_CTRL = 7'h02; // control register
  localparam logic [6:0] ADR_FAULT = 7'h05; // fault register
  // control register fields and reset
  localparam int CTL_TSEL_LO = 0; // watchdog timeout select, 3 bits
  localparam int CTL_WDT_EN = 3; // watchdog enable
  localparam int CTL_ARB_DIS = 4; // auto fault readback disable
  localparam logic [15:0] CTRL_RST = 16'h0008; // watchdog on, shortest timeout
  localparam logic [15:0] DAC_RST = 16'h0000; // loop code after reset
  // fault register bits
  localparam int FLT_SPI = 15; // serial link lost
  localparam int FLT_PKT_ERR = 14; // packet_check_error
  localparam int FLT_UNDER = 13; // loop current low
  localparam int FLT_OVER = 12; // loop current high
  localparam int FLT_TEMP = 11; // die temperature high
  // alarm loop codes
  localparam logic [15:0] ALARM_UP_CODE = 16'hffff; // upscale alarm
  localparam logic [15:0] ALARM_DN_CODE = 16'h0000; // downscale alarm
  // timing
  localparam int CLK_PERIOD_NS = 10; // hclk period
  localparam int WDT_UNIT_US = 1000; // watchdog base step
  localparam int WDT_UNIT_CYC = WDT_UNIT_US * 1000 / CLK_PERIOD_NS; // cycles per step
  localparam int SCLK_PERIOD_NS = 160; // serial clock period made by host
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS); // cycles per half
  // host ahb register offsets
  localparam logic [7:0] A_CMD = 8'h00; // frame to send
  localparam logic [7:0] A_STAT = 8'h04; // busy and fault pin
  localparam logic [7:0] A_RXD = 8'h08; // last received bits
  localparam logic [7:0] A_IRQ_ST = 8'h0c; // sticky events, read clears
  localparam logic [7:0] A_IRQ_MSK = 8'h10; // event mask
  localparam int CMD_CRC_BIT = 24; // send frame with check byte
  localparam int IRQ_DONE = 0; // frame finished
  localparam int IRQ_FAULT = 1; // fault pin rose
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END} host_st_t;

  // check byte over 24 bits, msb first
  function automatic logic [7:0] crc8_24(input logic [23:0] d);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction
endpackage

// ---- include/fault_link_if.sv ----
// serial link between host controller and fault alert device
interface fault_link_if;
  logic sclk; // serial clock from host
  logic sync_n; // frame sync, low during frame
  logic sdin; // data host to device
  logic sdo; // data device to host
  logic fault; // fault pin, high on any fault
  modport dev (input sclk, input sync_n, input sdin, output sdo, output fault);
  modport host (output sclk, output sync_n, output sdin, input sdo, input fault);
endinterface

// ---- sim/loop_dac_fault_alert_unit_assertions.sv ----
// concurrent checks on the serial link between host and device ends, and on the device alarm outputs
module loop_dac_fault_alert_unit_assertions
  import fault_alert_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic sclk, // serial clock
  input wire logic sync_n, // frame sync, active low
  input wire logic sdin, // host to device data
  input wire logic sdo, // device to host data
  input wire logic fault, // fault pin
  input wire logic alarm_up, // alarm direction strap
  input wire logic alarm_on, // loop forced to alarm
  input wire logic [15:0] loop_code // code driving the loop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  logic sclk_last_r; // last serial clock level
  logic [5:0] nbits_r; // serial clock rises in this frame
  // count rises while a frame is open
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_last_r <= 1'h0;
      nbits_r <= 6'h00;
    end else begin
      sclk_last_r <= sclk;
      if (sync_n) begin
        nbits_r <= 6'h00;
      end else if (sclk && !sclk_last_r) begin
        nbits_r <= nbits_r + 6'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence seq_lead; // clock low for half a period
    (!sclk) [*8];
  endsequence
  sequence seq_high; // clock high for half a period, then low
    sclk [*8] ##1 !sclk;
  endsequence
  AST_SCLK_IDLE: assert property (sync_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  AST_SYNC_LEAD: assert property ($fell(sync_n) |-> seq_lead)
    else $error("first clock rise came too early after sync");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> seq_high)
    else $error("serial clock high phase wrong");
  AST_SDIN_HOLD: assert property ($rose(sclk) |-> $stable(sdin) [*8])
    else $error("host data moved while clock high");
  AST_SDO_HOLD: assert property (!sync_n && $rose(sclk) |-> $stable(sdo) [*6])
    else $error("reply data moved while clock high");
  AST_BIT_COUNT: assert property ($rose(sync_n) |-> nbits_r == 6'h18 || nbits_r == 6'h20)
    else $error("frame length neither 24 nor 32");
  AST_ALARM_PIN: assert property ($rose(alarm_on) |-> ##[0:2] fault)
    else $error("alarm without fault pin");
  AST_ALARM_HOLD: assert property (alarm_on && sync_n |=> alarm_on)
    else $error("alarm dropped without a fault read");
  AST_ALARM_CODE: assert property ((alarm_on && $stable(alarm_up)) [*4] |->
    loop_code == (alarm_up ? ALARM_UP_CODE : ALARM_DN_CODE))
    else $error("loop code is not the alarm code");
endmodule // loop_dac_fault_alert_unit_assertions

// ---- sim/test_loop_dac_fault_alert_unit.sv ----
// testbench: host and device ends joined, plus a device fed by a bench driver
module test_loop_dac_fault_alert_unit
  import fault_alert_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0; // bus master side
  logic [7:0] haddr = 8'h00; // bus address
  logic [1:0] htrans = 2'h0; // transfer type
  logic [2:0] hsize = 3'h2; // word transfers
  logic [31:0] hwdata = 32'h0, hrdata; // bus data
  logic hreadyout, hresp, irq, alarm_on, alarm_on2; // design outputs
  logic [15:0] loop_code, loop_code2; // loop codes of both devices
  logic alarm_up = 1'h1, under = 1'h0, over = 1'h0, temp = 1'h0; // strap and monitors
  int errors = 0, num_checks = 0; // mismatches and comparisons
  fault_link_if lnk(); // host to device link
  fault_link_if lnk2(); // bench driver to second device
  always #5 hclk = ~hclk; // 100 MHz
  ////////////////////////////////////////////////////////////////////////////////
  fault_alert_host i_fault_alert_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .lnk(lnk.host));
  fault_alert_dev #(.WDT_UNIT(1000)) i_fault_alert_dev (.hclk(hclk), .hresetn(hresetn),
    .lnk(lnk.dev), .alarm_up(alarm_up), .loop_under(under), .loop_over(over), .temp_hi(temp),
    .loop_code(loop_code), .alarm_on(alarm_on));
  fault_alert_dev #(.WDT_UNIT(30000)) i_fault_alert_dev_b (.hclk(hclk), .hresetn(hresetn),
    .lnk(lnk2.dev), .alarm_up(alarm_up), .loop_under(1'h0), .loop_over(1'h0),
    .temp_hi(1'h0), .loop_code(loop_code2), .alarm_on(alarm_on2));
  loop_dac_fault_alert_unit_assertions i_loop_dac_fault_alert_unit_assertions (.hclk(hclk),
    .hresetn(hresetn), .sclk(lnk.sclk), .sync_n(lnk.sync_n), .sdin(lnk.sdin), .sdo(lnk.sdo),
    .fault(lnk.fault), .alarm_up(alarm_up), .alarm_on(alarm_on), .loop_code(loop_code));
  ////////////////////////////////////////////////////////////////////////////////
  // reference check byte, msb first, zero start
  function automatic logic [7:0] ref_crc(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rdv = hrdata;
  endtask
  // host sends a frame, waits for idle, returns received bits
  task automatic send(input logic [23:0] f, input logic crc, output logic [31:0] rx);
    logic [31:0] s;
    ahb(1'h1, A_CMD, {7'h00, crc, f}, s);
    s = 32'h1;
    for (int i = 0; i < 1000 && s[0] !== 1'h0; i++) ahb(1'h0, A_STAT, 32'h0, s);
    chk({31'h0, s[0]}, 32'h0);
    repeat (8) @(posedge hclk);
    ahb(1'h0, A_RXD, 32'h0, rx);
  endtask
  // bench frame on the second link, n bits msb first
  task automatic raw(input logic [31:0] w, input int n, output logic [31:0] got);
    got = 32'h0;
    lnk2.sync_n <= 1'h0;
    lnk2.sdin <= w[n-1];
    repeat (8) @(posedge hclk);
    for (int i = n - 1; i >= 0; i--) begin
      got[i] = lnk2.sdo;
      lnk2.sclk <= 1'h1;
      repeat (8) @(posedge hclk);
      lnk2.sclk <= 1'h0;
      lnk2.sdin <= (i > 0) ? w[i-1] : ~w[0];
      repeat (8) @(posedge hclk);
    end
    lnk2.sync_n <= 1'h1;
    repeat (20) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // write, then checked readback with appended byte
  task automatic t_readback();
    logic [31:0] rx;
    logic [23:0] r;
    send({1'h0, ADR_DAC, 16'h1234}, 1'h0, rx);
    chk({16'h0, loop_code}, 32'h1234);
    send({1'h1, ADR_DAC, 16'h0000}, 1'h1, rx);
    send({1'h0, ADR_NOP, 16'h0000}, 1'h1, rx);
    r = {1'h0, ADR_DAC, 16'h1234};
    chk(rx, {r, ref_crc(r)});
    $display("test readback done");
  endtask
  // each monitor raises the pin and its own fault bit
  task automatic t_monitors();
    logic [31:0] rx;
    for (int i = 0; i < 3; i++) begin
      under <= (i == 0);
      over <= (i == 1);
      temp <= (i == 2);
      repeat (6) @(posedge hclk);
      chk({31'h0, lnk.fault}, 32'h1);
      send({1'h1, ADR_FAULT, 16'h0000}, 1'h0, rx);
      send({1'h0, ADR_NOP, 16'h0000}, 1'h0, rx);
      chk({19'h0, rx[23:11]}, {19'h0, 1'h0, ADR_FAULT, 5'h04 >> i});
    end
    under <= 1'h0;
    temp <= 1'h0;
    repeat (6) @(posedge hclk);
    chk({31'h0, lnk.fault}, 32'h0);
    $display("test monitors done");
  endtask
  // link loss, alarm codes, interrupt, frozen watchdog until fault read
  task automatic t_watchdog();
    logic [31:0] rx;
    send({1'h0, ADR_CTRL, 16'h0018}, 1'h0, rx);
    send({1'h1, ADR_DAC, 16'h0000}, 1'h0, rx);
    repeat (880) @(posedge hclk);
    chk({31'h0, alarm_on}, 32'h0);
    for (int i = 0; i < 300 && alarm_on !== 1'h1; i++) @(posedge hclk);
    chk({31'h0, alarm_on}, 32'h1);
    repeat (6) @(posedge hclk);
    chk({16'h0, loop_code}, {16'h0, ALARM_UP_CODE});
    alarm_up <= 1'h0;
    repeat (6) @(posedge hclk);
    chk({16'h0, loop_code}, {16'h0, ALARM_DN_CODE});
    alarm_up <= 1'h1;
    chk({31'h0, irq}, 32'h0);
    ahb(1'h1, A_IRQ_MSK, 32'h2, rx);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    ahb(1'h0, A_STAT, 32'h0, rx);
    chk(rx & 32'h2, 32'h2);
    ahb(1'h0, A_IRQ_ST, 32'h0, rx);
    chk(rx & 32'h2, 32'h2);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    ahb(1'h0, 8'h20, 32'h0, rx);
    chk(rx, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    send({1'h0, ADR_DAC, 16'h4321}, 1'h0, rx);
    chk({31'h0, alarm_on}, 32'h1);
    send({1'h1, ADR_FAULT, 16'h0000}, 1'h0, rx);
    chk({31'h0, alarm_on}, 32'h1);
    send({1'h0, ADR_NOP, 16'h0000}, 1'h0, rx);
    chk({31'h0, rx[FLT_SPI]}, 32'h1);
    chk({31'h0, alarm_on}, 32'h0);
    chk({16'h0, loop_code}, 32'h4321);
    $display("test watchdog done");
  endtask
  // bad check byte on the second link
  task automatic t_check_byte();
    logic [31:0] got;
    logic [23:0] d;
    d = {1'h0, ADR_DAC, 16'habcd};
    raw({d, ref_crc(d) ^ 8'h01}, 32, got);
    chk({31'h0, lnk2.fault}, 32'h1);
    chk({16'h0, loop_code2}, {16'h0, DAC_RST});
    d = {1'h0, ADR_DAC, 16'h5a5a};
    raw({d, ref_crc(d)}, 32, got);
    chk({16'h0, loop_code2}, 32'h5a5a);
    raw({8'h00, 1'h0, ADR_NOP, 16'h0000}, 24, got);
    chk({24'h0, got[23:16]}, {24'h0, 1'h0, ADR_FAULT});
    chk({31'h0, got[FLT_PKT_ERR]}, 32'h1);
    chk({31'h0, lnk2.fault}, 32'h0);
    chk({31'h0, alarm_on2}, 32'h0);
    $display("test check byte done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // print counts and verdict, end the run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    lnk2.sclk = 1'h0;
    lnk2.sync_n = 1'h1;
    lnk2.sdin = 1'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    t_readback();
    t_monitors();
    t_watchdog();
    t_check_byte();
    tally_and_finish();
  end
  // hang guard
  initial begin
    #400000;
    errors++;
    $display("Error at %0t: run did not finish", $time);
    tally_and_finish();
  end
endmodule // test_loop_dac_fault_alert_unit
